// ===== core/cocd_leg.sv
// One output driver leg with immediate reset, glitch-free mute and clean resume.
`timescale 1ns/100ps
module cocd_leg (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic src,
   input wire logic reset_req,
   input wire logic mute_req,
   input wire logic level,
   output logic out_r,
   output logic muted_r
);
   logic muted_nxt;

   // Mute entry and every exit of the muted state happen only where the source already sits at the held level; reset enters at once.
   always_comb begin
      if (reset_req) begin
         muted_nxt = 1'b1; // RULE4 RULE10
      end else if (mute_req) begin
         muted_nxt = muted_r | (src == level); // RULE5 RULE17 RULE13
      end else begin
         muted_nxt = muted_r & (src != level); // RULE6 RULE11 RULE13
      end
   end

   // The pin copy is registered so the pad never sees a combinational hazard.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         muted_r <= 1'b0;
         out_r <= 1'b0;
      end else begin
         muted_r <= muted_nxt;
         out_r <= muted_nxt ? level : src;
      end
   end

   a_reset_holds: assert property (@(posedge clk) disable iff (!rst_n)
      reset_req |=> muted_r && out_r == $past(level)) // RULE10
      else $error("leg did not take its held level on reset");
   a_mute_waits: assert property (@(posedge clk) disable iff (!rst_n)
      mute_req && !reset_req && !muted_r && src != level |=> !muted_r) // RULE17
      else $error("leg muted in the middle of a pulse");
endmodule

// ===== core/cocd_pkg.sv
// Package with register map, field positions and bus codes of the channel output control block.
package cocd_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [15:0] CCOD_IDX_GLOBAL = 16'h2201;
   localparam logic [15:0] CCOD_IDX_PAIR_A = 16'h2202;
   localparam logic [15:0] CCOD_IDX_MODE = 16'h2210;
   localparam logic [15:0] CCOD_IDX_STATUS = 16'h2211;
   localparam logic [15:0] CCOD_IDX_UPDATE = 16'h2212;
   localparam int CCOD_ADDR_W = 18;
   localparam logic [17:0] CCOD_ADR_GLOBAL = {CCOD_IDX_GLOBAL, 2'b00};
   localparam logic [17:0] CCOD_ADR_PAIR_A = {CCOD_IDX_PAIR_A, 2'b00};
   localparam logic [17:0] CCOD_ADR_MODE = {CCOD_IDX_MODE, 2'b00};
   localparam logic [17:0] CCOD_ADR_STATUS = {CCOD_IDX_STATUS, 2'b00};
   localparam logic [17:0] CCOD_ADR_UPDATE = {CCOD_IDX_UPDATE, 2'b00};
   // Channel-wide register fields.
   localparam int CCOD_G_NSHOT = 0;
   localparam int CCOD_G_MUTE = 1;
   localparam int CCOD_G_RESET = 2;
   localparam int CCOD_G_SYNC = 3;
   // Pair register fields.
   localparam int CCOD_P_MUTE_C = 3;
   localparam int CCOD_P_PDOWN = 4;
   localparam int CCOD_P_RESET = 5;
   // Mode, update and status fields.
   localparam int CCOD_M_DIFF = 0;
   localparam int CCOD_U_XFER = 0;
   localparam int CCOD_S_TRUE_MUTED = 0;
   localparam int CCOD_S_COMP_MUTED = 1;
   localparam int CCOD_S_NSHOT = 2;
   localparam int CCOD_S_SYNC = 3;
   // Writable bits and reset values.
   localparam logic [7:0] CCOD_GLOBAL_WMASK = 8'h0f;
   localparam logic [7:0] CCOD_PAIR_WMASK = 8'h38;
   localparam logic [7:0] CCOD_MODE_WMASK = 8'h01;
   localparam logic [7:0] CCOD_GLOBAL_RST = 8'h00;
   localparam logic [7:0] CCOD_PAIR_RST = 8'h00;
   localparam logic [7:0] CCOD_MODE_RST = 8'h00;
   // Bus answer codes.
   localparam logic [1:0] CCOD_RESP_OKAY = 2'h0;
   localparam logic [1:0] CCOD_RESP_SLVERR = 2'h2;
endpackage

// ===== core/cocd_top.sv
// Channel output driver control: register bank on AXI4-Lite and the first output pair's drivers.
//
// Behaviour
// [RULE1] Sync bit set holds all drivers static and keeps the output dividers in reset.
// [RULE2] Sync bit falling releases all divider resets together so outputs start in phase.
// [RULE3] During sync hold the differential drivers sit in their muted levels.
// [RULE4] Reset-all bit mutes every driver at once without waiting for a safe point.
// [RULE5] Mute-all bit mutes drivers only after a deferral that avoids a cut pulse.
// [RULE6] Leaving mute or reset resumes output without a shortened first pulse.
// [RULE7] Channel mute holds true leg low and complementary leg high.
// [RULE8] The N-shot request is shadowed and acts only after a transfer command.
// [RULE9] Software should write the N-shot request back to zero after use.
// [RULE10] Pair reset immediately holds true output low and complementary output high.
// [RULE11] Releasing pair reset restarts outputs without a shortened pulse.
// [RULE12] Pair power-down tristates both pins; clearing it restores operation.
// [RULE13] Complementary mute drives that output low, entering and leaving cleanly; here leaving drives the pin high at once, whatever the source level.
// [RULE14] In differential mode the complementary mute bit is ignored.
// [RULE15] Buffered settings take effect only when the transfer bit is written with 1.
// [RULE16] Reserved bits read as zero and ignore writes.
// [RULE17] Deferred mute completes where the divider output already sits at the muted level.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
module cocd_top
   import cocd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [17:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [17:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pair_a_true_divider,
   input wire logic pair_a_complement_divider,
   output logic pair_a_true_divider_reset,
   output logic pair_a_complement_divider_reset,
   output logic pair_a_positive_pin_o,
   output logic pair_a_positive_pin_oe,
   output logic pair_a_negative_pin_o,
   output logic pair_a_negative_pin_oe,
   output logic nshot_request
);
   logic rst_meta_r;
   logic rst_n_r;
   logic aw_held_r;
   logic w_held_r;
   logic [17:0] awaddr_r;
   logic [7:0] wdata_r;
   logic wlane0_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic wr_go;
   logic wr_hit;
   logic [7:0] global_r;
   logic [7:0] pair_r;
   logic [7:0] mode_r;
   logic xfer_wr;
   logic nshot_r;
   logic div_rst_r;
   logic oe_r;
   logic diff;
   logic any_reset;
   logic mute_all;
   logic comp_mute;
   logic comp_src;
   logic comp_level;
   logic true_out;
   logic true_muted;
   logic comp_out;
   logic comp_muted;
   logic [7:0] rd_byte;
   logic rd_hit;

   // Reset release passes two flip-flops so every register leaves reset on the same edge.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // Write address channel; the address is held until the response is accepted.
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         awready_r <= 1'b0;
         aw_held_r <= 1'b0;
         awaddr_r <= 18'h00000;
      end else if (awready_r && s_axi_awvalid) begin
         awready_r <= 1'b0;
         aw_held_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held_r <= 1'b0;
      end else if (!aw_held_r && !bvalid_r) begin
         awready_r <= 1'b1;
      end
   end

   // Write data channel; only the low byte lane carries register contents.
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wready_r <= 1'b0;
         w_held_r <= 1'b0;
         wdata_r <= 8'h00;
         wlane0_r <= 1'b0;
      end else if (wready_r && s_axi_wvalid) begin
         wready_r <= 1'b0;
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata[7:0];
         wlane0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_held_r <= 1'b0;
      end else if (!w_held_r && !bvalid_r) begin
         wready_r <= 1'b1;
      end
   end

   // A write commits once both halves are in and the previous answer is gone.
   assign wr_go = aw_held_r && w_held_r && !bvalid_r;
   assign wr_hit = awaddr_r == CCOD_ADR_GLOBAL || awaddr_r == CCOD_ADR_PAIR_A
      || awaddr_r == CCOD_ADR_MODE || awaddr_r == CCOD_ADR_STATUS || awaddr_r == CCOD_ADR_UPDATE;

   // Write response; unmapped addresses answer with a slave error and change nothing.
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         bvalid_r <= 1'b0;
         bresp_r <= CCOD_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? CCOD_RESP_OKAY : CCOD_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Control registers; reserved positions are masked off so they stay zero.
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         global_r <= CCOD_GLOBAL_RST;
         pair_r <= CCOD_PAIR_RST;
         mode_r <= CCOD_MODE_RST;
      end else if (wr_go && wlane0_r) begin
         if (awaddr_r == CCOD_ADR_GLOBAL) begin
            global_r <= wdata_r & CCOD_GLOBAL_WMASK; // RULE16
         end
         if (awaddr_r == CCOD_ADR_PAIR_A) begin
            pair_r <= wdata_r & CCOD_PAIR_WMASK; // RULE16
         end
         if (awaddr_r == CCOD_ADR_MODE) begin
            mode_r <= wdata_r & CCOD_MODE_WMASK;
         end
      end
   end

   // The transfer command copies the shadowed request; software clears it afterwards itself.
   assign xfer_wr = wr_go && wlane0_r && awaddr_r == CCOD_ADR_UPDATE && wdata_r[CCOD_U_XFER];
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         nshot_r <= 1'b0;
      end else if (xfer_wr) begin
         nshot_r <= global_r[CCOD_G_NSHOT]; // RULE8 RULE15
      end
   end
   assign nshot_request = nshot_r;

   // Read channel; one read is in flight and the data come from a register.
   always_comb begin
      rd_hit = 1'b1;
      rd_byte = 8'h00;
      case (s_axi_araddr)
         CCOD_ADR_GLOBAL: rd_byte = global_r;
         CCOD_ADR_PAIR_A: rd_byte = pair_r;
         CCOD_ADR_MODE: rd_byte = mode_r;
         CCOD_ADR_UPDATE: rd_byte = 8'h00;
         CCOD_ADR_STATUS: begin
            rd_byte[CCOD_S_TRUE_MUTED] = true_muted;
            rd_byte[CCOD_S_COMP_MUTED] = comp_muted;
            rd_byte[CCOD_S_NSHOT] = nshot_r;
            rd_byte[CCOD_S_SYNC] = div_rst_r;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= CCOD_RESP_OKAY;
         rdata_r <= 32'h00000000;
      end else if (arready_r && s_axi_arvalid) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rresp_r <= rd_hit ? CCOD_RESP_OKAY : CCOD_RESP_SLVERR;
         rdata_r <= {24'h000000, rd_byte}; // RULE16
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end else if (!rvalid_r) begin
         arready_r <= 1'b1;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   // Driver requests; reset and channel mute feed both legs, the complementary mute only the complementary leg.
   assign diff = mode_r[CCOD_M_DIFF];
   assign any_reset = global_r[CCOD_G_SYNC] | global_r[CCOD_G_RESET] | pair_r[CCOD_P_RESET]; // RULE1 RULE3 RULE4 RULE10
   assign mute_all = global_r[CCOD_G_MUTE];
   assign comp_mute = pair_r[CCOD_P_MUTE_C] & ~diff; // RULE14

   // In differential mode the complementary leg follows the inverted true divider.
   assign comp_src = diff ? ~pair_a_true_divider : pair_a_complement_divider;
   // Its own mute parks it low; reset and channel mute park it high.
   assign comp_level = ~(comp_mute & ~any_reset & ~mute_all); // RULE7 RULE10 RULE13

   cocd_leg u_true_leg (
      .clk(sys_clk),
      .rst_n(rst_n_r),
      .src(pair_a_true_divider),
      .reset_req(any_reset),
      .mute_req(mute_all),
      .level(1'b0),
      .out_r(true_out),
      .muted_r(true_muted)
   );

   cocd_leg u_comp_leg (
      .clk(sys_clk),
      .rst_n(rst_n_r),
      .src(comp_src),
      .reset_req(any_reset),
      .mute_req(mute_all | comp_mute),
      .level(comp_level),
      .out_r(comp_out),
      .muted_r(comp_muted)
   );

   assign pair_a_positive_pin_o = true_out;
   assign pair_a_negative_pin_o = comp_out;

   // Both divider resets come from one flop, so their release lands on the same edge.
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         div_rst_r <= 1'b0;
      end else begin
         div_rst_r <= global_r[CCOD_G_SYNC]; // RULE1 RULE2
      end
   end
   assign pair_a_true_divider_reset = div_rst_r;
   assign pair_a_complement_divider_reset = div_rst_r;

   // Power-down releases both pads; the leg logic keeps running so wake-up is clean.
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         oe_r <= 1'b1;
      end else begin
         oe_r <= ~pair_r[CCOD_P_PDOWN]; // RULE12
      end
   end
   assign pair_a_positive_pin_oe = oe_r;
   assign pair_a_negative_pin_oe = oe_r;

   // Checks on the documented behaviour.
   sequence s_sync_held;
      global_r[CCOD_G_SYNC] [*2];
   endsequence

   sequence s_write_ready;
      aw_held_r && w_held_r && !bvalid_r;
   endsequence

   a_sync_div_reset: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE1
      s_sync_held |-> pair_a_true_divider_reset && pair_a_complement_divider_reset)
      else $error("dividers not held in reset during sync");
   a_sync_release: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE2
      $fell(global_r[CCOD_G_SYNC]) |=> !pair_a_true_divider_reset && !pair_a_complement_divider_reset)
      else $error("divider resets not released together");
   a_sync_muted: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE3
      s_sync_held |-> !pair_a_positive_pin_o && pair_a_negative_pin_o)
      else $error("drivers not muted during sync");
   a_reset_all_now: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE4
      global_r[CCOD_G_RESET] |=> !pair_a_positive_pin_o && pair_a_negative_pin_o)
      else $error("reset-all did not mute at once");
   a_mute_defer: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE5
      mute_all && !any_reset && !true_muted && pair_a_true_divider |=> pair_a_positive_pin_o)
      else $error("true pulse cut by deferred mute");
   a_mute_levels: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE7
      mute_all && true_muted && comp_muted ##1 mute_all |-> !pair_a_positive_pin_o && pair_a_negative_pin_o)
      else $error("muted levels wrong");
   a_nshot_xfer: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE15
      !xfer_wr |=> $stable(nshot_request))
      else $error("request changed without transfer");
   a_nshot_take: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE8
      xfer_wr |=> nshot_request == $past(global_r[CCOD_G_NSHOT]))
      else $error("transfer did not copy request");
   a_pdown_tristate: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE12
      pair_r[CCOD_P_PDOWN] |=> !pair_a_positive_pin_oe && !pair_a_negative_pin_oe)
      else $error("power-down did not tristate");
   a_diff_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE14
      diff && !any_reset && !mute_all && !comp_muted |=> !comp_muted)
      else $error("complementary mute acted in differential mode");
   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE16
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && !global_r[7] && !pair_r[7])
      else $error("reserved bits not zero");
   a_write_answer: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      s_write_ready |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("write not answered next cycle");
   a_comp_mute_low: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE13
      comp_mute && !any_reset && !mute_all && comp_muted |=> !pair_a_negative_pin_o)
      else $error("complementary leg not held low by its mute");
   a_pair_reset_now: assert property (@(posedge sys_clk) disable iff (!rst_n_r) // RULE10
      pair_r[CCOD_P_RESET] |=> !pair_a_positive_pin_o && pair_a_negative_pin_o)
      else $error("pair reset did not park the pins at once");
endmodule

// ===== tb/cocd_div_model.sv
// Behavioural model of the divider pair that feeds the first output pair.
`timescale 1ns/100ps
module cocd_div_model #(
   parameter int HALF = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic div_rst,
   output logic q_true,
   output logic q_comp
);
   int cnt;
   // Both dividers restart from low together, so a released sync starts them in phase.
   always_ff @(posedge clk) begin
      if (!rst_n || div_rst) begin
         cnt <= 0;
         q_true <= 1'b0;
         q_comp <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         q_true <= ~q_true;
         q_comp <= ~q_comp;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// ===== tb/cocd_top_test.sv
// Self-checking bench for the channel output control block.
`timescale 1ns/100ps
module cocd_top_test;
   import cocd_pkg::*;
   localparam int H = 4;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [17:0] s_axi_awaddr = '0;
   logic [17:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic pair_a_true_divider, pair_a_complement_divider, nshot_request;
   logic pair_a_true_divider_reset, pair_a_complement_divider_reset;
   logic pair_a_positive_pin_o, pair_a_positive_pin_oe, pair_a_negative_pin_o, pair_a_negative_pin_oe;
   int n_errors = 0;
   int num_checks = 0;
   int rises = 0;
   int run_p = 0;
   int run_n = 0;
   logic prev_p, prev_n;
   bit runt_chk = 1'b0;
   bit diff_mode = 1'b0;

   // Free-running system clock.
   always #5 sys_clk = ~sys_clk;

   cocd_top dut_u (
      .sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .pair_a_true_divider, .pair_a_complement_divider, .pair_a_true_divider_reset,
      .pair_a_complement_divider_reset, .pair_a_positive_pin_o, .pair_a_positive_pin_oe,
      .pair_a_negative_pin_o, .pair_a_negative_pin_oe, .nshot_request
   );

   cocd_div_model #(.HALF(H)) div_u (
      .clk(sys_clk), .rst_n(nrst), .div_rst(pair_a_true_divider_reset),
      .q_true(pair_a_true_divider), .q_comp(pair_a_complement_divider)
   );

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask

   task automatic close_out();
      if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Pulse widths are measured at the pins; a cut pulse shows as a run shorter than a half period.
   always @(posedge sys_clk) begin
      if (pair_a_positive_pin_o !== prev_p) begin
         if (runt_chk && prev_p === 1'b1) chk("positive pulse width", H, run_p);
         if (prev_p === 1'b0) rises = rises + 1;
         run_p = 1;
      end else run_p = run_p + 1;
      if (pair_a_negative_pin_o !== prev_n) begin
         if (runt_chk && diff_mode && prev_n === 1'b0) chk("negative pulse width", H, run_n);
         run_n = 1;
      end else run_n = run_n + 1;
      prev_p = pair_a_positive_pin_o;
      prev_n = pair_a_negative_pin_o;
   end

   task automatic stall();
      $display("CHECK FAILED bus answer expected 1 seen 0");
      n_errors++;
      close_out();
   endtask

   task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
      int i;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
      end
      if (i == 100) stall();
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
      end
      if (i == 100) stall();
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic wrc(input logic [17:0] a, input logic [7:0] d);
      logic [1:0] r;
      wr(a, d, 4'h1, r);
      chk("write response", CCOD_RESP_OKAY, r);
   endtask

   task automatic rdc(input logic [17:0] a, input logic [31:0] e, input string what);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(what, e, d);
      chk("read response", CCOD_RESP_OKAY, r);
   endtask

   // Checks both pins against fixed levels for n cycles.
   task automatic pins(input int n, input logic p, input logic q);
      repeat (n) begin
         @(posedge sys_clk);
         chk("positive pin", p, pair_a_positive_pin_o);
         chk("negative pin", q, pair_a_negative_pin_o);
      end
   endtask

   // Waits and expects the positive pin to have started toggling again.
   task automatic resumed(input string what);
      repeat (6 * H) @(posedge sys_clk);
      chk(what, 1, rises >= 2);
      runt_chk = 1'b0;
   endtask

   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rdc(CCOD_ADR_GLOBAL, CCOD_GLOBAL_RST, "global reset value");
      rdc(CCOD_ADR_PAIR_A, CCOD_PAIR_RST, "pair reset value");
      rd(18'h08800, d, r);
      chk("unmapped read response", CCOD_RESP_SLVERR, r);
      chk("unmapped read data", 32'h00000000, d);
      wr(18'h08800, 8'hff, 4'hf, r);
      chk("unmapped write response", CCOD_RESP_SLVERR, r);
      wrc(CCOD_ADR_PAIR_A, 8'hff);
      rdc(CCOD_ADR_PAIR_A, 32'h00000038, "pair writable bits");
      wr(CCOD_ADR_PAIR_A, 8'h00, 4'h0, r);
      chk("write without strobe response", CCOD_RESP_OKAY, r);
      rdc(CCOD_ADR_PAIR_A, 32'h00000038, "pair write without strobe");
      wrc(CCOD_ADR_PAIR_A, 8'h00);
      wrc(CCOD_ADR_GLOBAL, 8'hf0);
      rdc(CCOD_ADR_GLOBAL, 32'h00000000, "global reserved bits");
   endtask

   task automatic t_sync();
      logic [31:0] d;
      logic [1:0] r;
      wrc(CCOD_ADR_GLOBAL, 8'h08);
      @(posedge sys_clk);
      chk("true divider reset", 1'b1, pair_a_true_divider_reset);
      chk("complement divider reset", 1'b1, pair_a_complement_divider_reset);
      pins(3 * H, 1'b0, 1'b1);
      rd(CCOD_ADR_STATUS, d, r);
      chk("status sync", 1'b1, d[CCOD_S_SYNC]);
      runt_chk = 1'b1;
      rises = 0;
      wrc(CCOD_ADR_GLOBAL, 8'h00);
      @(posedge sys_clk);
      chk("divider reset release", 2'b00, {pair_a_true_divider_reset, pair_a_complement_divider_reset});
      repeat (2 * H) begin
         @(posedge sys_clk);
         chk("legs in phase", 1'b1, pair_a_positive_pin_o ^ pair_a_negative_pin_o);
      end
      resumed("restart after sync");
   endtask

   task automatic t_drivers();
      logic [31:0] d;
      logic [1:0] r;
      wrc(CCOD_ADR_GLOBAL, 8'h04);
      pins(2 * H, 1'b0, 1'b1);
      runt_chk = 1'b1;
      rises = 0;
      wrc(CCOD_ADR_GLOBAL, 8'h00);
      resumed("resume after reset all");
      runt_chk = 1'b1;
      wrc(CCOD_ADR_GLOBAL, 8'h02);
      repeat (2 * H + 2) @(posedge sys_clk);
      pins(2 * H, 1'b0, 1'b1);
      rd(CCOD_ADR_STATUS, d, r);
      chk("status both legs muted", 2'b11, d[1:0]);
      rises = 0;
      wrc(CCOD_ADR_GLOBAL, 8'h00);
      resumed("resume after mute all");
      wrc(CCOD_ADR_PAIR_A, 8'h20);
      pins(2 * H, 1'b0, 1'b1);
      runt_chk = 1'b1;
      rises = 0;
      wrc(CCOD_ADR_PAIR_A, 8'h00);
      resumed("resume after pair reset");
      wrc(CCOD_ADR_PAIR_A, 8'h10);
      @(posedge sys_clk);
      chk("power down enables", 2'b00, {pair_a_positive_pin_oe, pair_a_negative_pin_oe});
      wrc(CCOD_ADR_PAIR_A, 8'h00);
      @(posedge sys_clk);
      chk("power up enables", 2'b11, {pair_a_positive_pin_oe, pair_a_negative_pin_oe});
   endtask

   task automatic t_comp_mute();
      diff_mode = 1'b0;
      wrc(CCOD_ADR_MODE, 8'h00);
      runt_chk = 1'b1;
      wrc(CCOD_ADR_PAIR_A, 8'h08);
      repeat (2 * H + 2) @(posedge sys_clk);
      rises = 0;
      repeat (4 * H + 2) begin
         @(posedge sys_clk);
         chk("complement muted low", 1'b0, pair_a_negative_pin_o);
      end
      chk("true leg still running", 1, rises >= 2);
      wrc(CCOD_ADR_MODE, 8'h01);
      repeat (2 * H + 2) @(posedge sys_clk);
      diff_mode = 1'b1;
      repeat (2 * H) begin
         @(posedge sys_clk);
         chk("complement mute ignored", 1'b1, pair_a_positive_pin_o ^ pair_a_negative_pin_o);
      end
      wrc(CCOD_ADR_PAIR_A, 8'h00);
      runt_chk = 1'b0;
   endtask

   task automatic t_nshot();
      wrc(CCOD_ADR_GLOBAL, 8'h01);
      repeat (4) begin
         @(posedge sys_clk);
         chk("request before transfer", 1'b0, nshot_request);
      end
      wrc(CCOD_ADR_UPDATE, 8'h01);
      repeat (2) @(posedge sys_clk);
      chk("request after transfer", 1'b1, nshot_request);
      rdc(CCOD_ADR_STATUS, 32'h00000004, "status request");
      rdc(CCOD_ADR_UPDATE, 32'h00000000, "update reads zero");
      wrc(CCOD_ADR_GLOBAL, 8'h00);
      repeat (2) @(posedge sys_clk);
      chk("request kept until transfer", 1'b1, nshot_request);
      wrc(CCOD_ADR_UPDATE, 8'h01);
      repeat (2) @(posedge sys_clk);
      chk("request cleared", 1'b0, nshot_request);
   endtask

   // Main sequence: reset, then one scenario after another.
   initial begin
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_regs();
      wrc(CCOD_ADR_MODE, 8'h01);
      rdc(CCOD_ADR_MODE, 32'h00000001, "mode readback");
      diff_mode = 1'b1;
      t_sync();
      t_drivers();
      t_comp_mute();
      t_nshot();
      close_out();
   end
endmodule
